//--- include/pvc_pkg.sv
// Purpose: Constants and types of the panel RAM and COMMON_ELECTRODE_VOLTAGE command block
// Assumes: 25 MHz pclk, serial link sampled by pclk
// Notes: Operation list below
package pvc_pkg;
    localparam int CLK_MHZ = 25;
    // ==================================================
    // Command codes
    localparam logic [7:0] CMD_WR_RED = 8'h26;
    localparam logic [7:0] CMD_RD_RAM = 8'h27;
    localparam logic [7:0] CMD_SENSE = 8'h28;
    localparam logic [7:0] CMD_SENSE_DUR = 8'h29;
    localparam logic [7:0] CMD_PROG = 8'h2a;
    localparam logic [7:0] CMD_GLITCH = 8'h2b;
    localparam logic [7:0] CMD_STATUS = 8'h2f;
    localparam logic [7:0] GLITCH_B0 = 8'h04;
    localparam logic [7:0] GLITCH_B1 = 8'h63;
    localparam logic [7:0] DUMMY_BYTE = 8'h00;
    localparam int STAT_BUSY_BIT = 2;
    // ==================================================
    // Timing
    localparam int SENSE_UNIT_NS = 1000;
    localparam int SENSE_UNIT_CYC = (SENSE_UNIT_NS * CLK_MHZ + 999) / 1000;
    localparam int PROG_TIME_NS = 10000;
    localparam int PROG_CYC = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 16;
    localparam int DUR_W = 4;
    // ==================================================
    // Register map
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_ADDR = 8'h08;
    localparam logic [7:0] OFS_COMMON_ELECTRODE_VOLTAGE = 8'h0c;
    localparam logic [7:0] OFS_DUR = 8'h10;
    localparam logic [7:0] OFS_GLITCH = 8'h14;
    localparam logic [7:0] OFS_INT_STAT = 8'h18;
    localparam logic [7:0] OFS_INT_MASK = 8'h1c;
    localparam int CTRL_W = 6;
    localparam logic [5:0] CTRL_RESET = 6'h18;
    localparam int INT_W = 4;
    localparam int INT_SENSE = 0;
    localparam int INT_PROG = 1;
    localparam int INT_GLITCH = 2;
    localparam int INT_REFUSE = 3;
    // ==================================================
    // Types
    typedef struct packed {
        logic address_step_direction;
        logic [1:0] address_inc_dec_select;
        logic read_red;
        logic analog_enable_flag;
        logic clock_enable_flag;
    } pvc_ctrl_t;
    typedef struct packed {
        logic dc;
        logic [7:0] data;
    } pvc_byte_t;
    typedef enum logic [2:0] {
        OP_IDLE = 3'b001,
        OP_SENSE = 3'b010,
        OP_PROG = 3'b100
    } pvc_op_t;
endpackage

//--- src/pvc_pixel_mem.sv
// Purpose: One pixel plane, one byte per address
// Assumes: Single clock, write and read on the same address
// Notes: Read data come from a register, one cycle late
module pvc_pixel_mem
#(
    parameter int AW = 13
)
(
    // Clock
    input logic clk,
    // Access
    input logic we,
    input logic [AW-1:0] addr,
    input logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [2**AW];

    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

//--- src/pvc_spi_link.sv
// Purpose: Serial byte link, pins sampled by pclk
// Assumes: Clock idles low, data taken on rising, changed on falling
// Notes: Host leaves four pclk cycles after select falls
module pvc_spi_link
    import pvc_pkg::*;
(
    // Clock and reset
    input logic pclk,
    input logic presetn,
    // Pins
    input logic sclk,
    input logic csn,
    input logic dcn,
    input logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Bytes
    output pvc_byte_t rx,
    output logic rx_valid,
    input logic [7:0] tx_byte,
    input logic tx_en
);
    logic [3:0] meta_reg;
    logic [3:0] sync_reg;
    logic [3:0] last_reg;
    logic [2:0] bit_cnt_reg;
    logic [6:0] shift_reg;
    logic [7:0] tx_shift_reg;
    logic load_dly_reg;
    logic rx_valid_reg;
    pvc_byte_t rx_reg;
    logic sclk_s, cs_s, dc_s, sda_s, rise, fall, cs_fall;

    // ==================================================
    // Pin synchronisers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_reg <= 4'hf;
            sync_reg <= 4'hf;
            last_reg <= 4'hf;
        end
        else
        begin
            meta_reg <= {sclk, csn, dcn, sda_in};
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end
    assign sclk_s = sync_reg[3];
    assign cs_s = ~sync_reg[2];
    assign dc_s = sync_reg[1];
    assign sda_s = sync_reg[0];
    assign rise = cs_s & sclk_s & ~last_reg[3];
    assign fall = cs_s & ~sclk_s & last_reg[3];
    assign cs_fall = cs_s & last_reg[2];

    // ==================================================
    // Receive
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bit_cnt_reg <= 3'h0;
            shift_reg <= 7'h00;
            rx_reg <= '0;
            rx_valid_reg <= 1'b0;
        end
        else
        begin
            rx_valid_reg <= 1'b0;
            if (!cs_s)
            begin
                bit_cnt_reg <= 3'h0;
            end
            else if (rise)
            begin
                bit_cnt_reg <= 3'(bit_cnt_reg + 3'h1);
                shift_reg <= {shift_reg[5:0], sda_s};
                if (bit_cnt_reg == 3'h7)
                begin
                    rx_reg <= '{dc: dc_s, data: {shift_reg, sda_s}};
                    rx_valid_reg <= 1'b1;
                end
            end
        end
    end
    assign rx = rx_reg;
    assign rx_valid = rx_valid_reg;

    // ==================================================
    // Transmit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_shift_reg <= 8'h00;
            load_dly_reg <= 1'b0;
        end
        else
        begin
            load_dly_reg <= cs_fall;
            if (load_dly_reg || (fall && bit_cnt_reg == 3'h0))
            begin
                tx_shift_reg <= tx_byte;
            end
            else if (fall)
            begin
                tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
            end
        end
    end
    assign sda_out = tx_shift_reg[7];
    assign sda_oe_n = ~(tx_en & cs_s & dc_s);
endmodule

//--- src/pvc_top.sv
// Purpose: Command handler for red plane, readback and COMMON_ELECTRODE_VOLTAGE commands
// Assumes: APB slave at pclk, serial link pins sampled by pclk
// Notes: Commands arriving while busy are dropped
//
// The placing of the registers and register access over APB are this design's own decisions.
module pvc_top
    import pvc_pkg::*;
#(
    parameter int X_W = 4,
    parameter int Y_W = 9,
    parameter int SENSE_UNIT = SENSE_UNIT_CYC,
    parameter int PROG_TIME = PROG_CYC,
    parameter logic [1:0] CHIP_ID = 2'b10 // Arbitrary value
)
(
    // Clock and reset
    input logic pclk,
    input logic presetn,
    // APB
    input logic [7:0] paddr,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial link
    input logic sclk,
    input logic csn,
    input logic dcn,
    input logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Black/white plane writer
    input logic bw_wr_en,
    input logic [7:0] bw_wr_data,
    // Analog and OTP
    input logic [7:0] sensed_common_electrode_voltage,
    output logic sense_active,
    output logic otp_write_en,
    output logic [7:0] otp_wdata,
    // Status
    output logic busy,
    output logic irq
);
    localparam int AW = X_W + Y_W;

    pvc_byte_t rx;
    logic rx_valid;
    pvc_ctrl_t ctrl_reg;
    pvc_op_t op_reg;
    logic [7:0] cmd_reg;
    logic [1:0] pidx_reg;
    logic first_reg;
    logic [DUR_W-1:0] dur_reg;
    logic [7:0] glitch0_reg;
    logic [7:0] glitch1_reg;
    logic [7:0] common_electrode_voltage_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic busy_reg;
    logic [X_W-1:0] x_reg;
    logic [Y_W-1:0] y_reg;
    logic [X_W-1:0] x_next;
    logic [Y_W-1:0] y_next;
    logic [7:0] tx_byte_reg;
    logic [INT_W-1:0] int_stat_reg;
    logic [INT_W-1:0] int_mask_reg;
    logic [INT_W-1:0] ev;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic [7:0] red_rdata;
    logic [7:0] bw_rdata;
    logic [7:0] plane_rdata;
    logic cmd_take, data_take, red_we, rd_done, addr_step;
    logic sense_ok, prog_ok, x_wrap, y_wrap, wr_acc, addr_wr;
    logic glitch_bad;

    // ==================================================
    // Link and planes
    pvc_spi_link u_link (
        .pclk(pclk),
        .presetn(presetn),
        .sclk(sclk),
        .csn(csn),
        .dcn(dcn),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe_n(sda_oe_n),
        .rx(rx),
        .rx_valid(rx_valid),
        .tx_byte(tx_byte_reg),
        .tx_en(cmd_reg == CMD_RD_RAM || cmd_reg == CMD_STATUS)
    );

    pvc_pixel_mem #(.AW(AW)) u_red (
        .clk(pclk),
        .we(red_we),
        .addr({y_reg, x_reg}),
        .wdata(rx.data),
        .rdata(red_rdata)
    );

    pvc_pixel_mem #(.AW(AW)) u_bw (
        .clk(pclk),
        .we(bw_wr_en & ~red_we),
        .addr({y_reg, x_reg}),
        .wdata(bw_wr_data),
        .rdata(bw_rdata)
    );

    // ==================================================
    // Byte decode
    assign cmd_take = rx_valid & ~rx.dc & (op_reg == OP_IDLE);
    assign data_take = rx_valid & rx.dc;
    assign red_we = data_take & (cmd_reg == CMD_WR_RED);
    assign rd_done = data_take & (cmd_reg == CMD_RD_RAM);
    assign addr_step = red_we | bw_wr_en | (rd_done & ~first_reg);
    assign plane_rdata = ctrl_reg.read_red ? red_rdata : bw_rdata;
    assign sense_ok = ctrl_reg.clock_enable_flag
        & ctrl_reg.analog_enable_flag;
    assign prog_ok = ctrl_reg.clock_enable_flag;
    assign glitch_bad = data_take & (cmd_reg == CMD_GLITCH)
        & (pidx_reg == 2'd2 || rx.data != (pidx_reg[0] ? GLITCH_B1 :
        GLITCH_B0));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_reg <= 8'h00;
            pidx_reg <= 2'd0;
            first_reg <= 1'b0;
        end
        else if (cmd_take)
        begin
            cmd_reg <= rx.data;
            pidx_reg <= 2'd0;
            first_reg <= (rx.data == CMD_RD_RAM);
        end
        else if (data_take)
        begin
            if (pidx_reg != 2'd2)
            begin
                pidx_reg <= 2'(pidx_reg + 2'd1);
            end
            if (rd_done)
            begin
                first_reg <= 1'b0;
            end
        end
    end

    // Parameter bytes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dur_reg <= '0;
            glitch0_reg <= 8'h00;
            glitch1_reg <= 8'h00;
        end
        else if (data_take && pidx_reg == 2'd0)
        begin
            if (cmd_reg == CMD_SENSE_DUR)
            begin
                dur_reg <= rx.data[DUR_W-1:0];
            end
            if (cmd_reg == CMD_GLITCH)
            begin
                glitch0_reg <= rx.data;
            end
        end
        else if (data_take && pidx_reg == 2'd1 && cmd_reg == CMD_GLITCH)
        begin
            glitch1_reg <= rx.data;
        end
    end

    // ==================================================
    // Read data for the link
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_byte_reg <= 8'h00;
        end
        else if (cmd_reg == CMD_STATUS)
        begin
            tx_byte_reg <= {5'h00, busy_reg, CHIP_ID};
        end
        else if (cmd_reg == CMD_RD_RAM)
        begin
            tx_byte_reg <= first_reg ? DUMMY_BYTE : plane_rdata;
        end
    end

    // ==================================================
    // Address counter
    always_comb
    begin
        x_wrap = ctrl_reg.address_inc_dec_select[0] ? (&x_reg) : ~|x_reg;
        y_wrap = ctrl_reg.address_inc_dec_select[1] ? (&y_reg) : ~|y_reg;
        x_next = ctrl_reg.address_inc_dec_select[0] ?
            X_W'(x_reg + 1'b1) : X_W'(x_reg - 1'b1);
        y_next = ctrl_reg.address_inc_dec_select[1] ?
            Y_W'(y_reg + 1'b1) : Y_W'(y_reg - 1'b1);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            x_reg <= '0;
            y_reg <= '0;
        end
        else if (addr_wr)
        begin
            x_reg <= pwdata[X_W-1:0];
            y_reg <= pwdata[AW-1:X_W];
        end
        else if (addr_step && !ctrl_reg.address_step_direction)
        begin
            x_reg <= x_next;
            if (x_wrap)
            begin
                y_reg <= y_next;
            end
        end
        else if (addr_step)
        begin
            y_reg <= y_next;
            if (y_wrap)
            begin
                x_reg <= x_next;
            end
        end
    end

    // ==================================================
    // Sense and program sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            op_reg <= OP_IDLE;
            cnt_reg <= '0;
            busy_reg <= 1'b0;
        end
        else
        begin
            unique case (op_reg)
                OP_IDLE:
                begin
                    if (cmd_take && rx.data == CMD_SENSE && sense_ok)
                    begin
                        op_reg <= OP_SENSE;
                        cnt_reg <= CNT_W'((int'(dur_reg) + 1)
                            * SENSE_UNIT - 1);
                        busy_reg <= 1'b1;
                    end
                    else if (cmd_take && rx.data == CMD_PROG && prog_ok)
                    begin
                        op_reg <= OP_PROG;
                        cnt_reg <= CNT_W'(PROG_TIME - 1);
                        busy_reg <= 1'b1;
                    end
                end
                OP_SENSE, OP_PROG:
                begin
                    if (cnt_reg == '0)
                    begin
                        op_reg <= OP_IDLE;
                        busy_reg <= 1'b0;
                    end
                    else
                    begin
                        cnt_reg <= CNT_W'(cnt_reg - 1'b1);
                    end
                end
            endcase
        end
    end
    assign busy = busy_reg;
    assign sense_active = (op_reg == OP_SENSE);
    assign otp_write_en = (op_reg == OP_PROG);
    assign otp_wdata = common_electrode_voltage_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            common_electrode_voltage_reg <= 8'h00;
        end
        else if (op_reg == OP_SENSE && cnt_reg == '0)
        begin
            common_electrode_voltage_reg <= sensed_common_electrode_voltage;
        end
        else if (wr_acc && paddr == OFS_COMMON_ELECTRODE_VOLTAGE)
        begin
            common_electrode_voltage_reg <= pwdata[7:0];
        end
    end

    // ==================================================
    // Events and interrupt
    always_comb
    begin
        ev = '0;
        ev[INT_SENSE] = (op_reg == OP_SENSE) && (cnt_reg == '0);
        ev[INT_PROG] = (op_reg == OP_PROG) && (cnt_reg == '0);
        ev[INT_GLITCH] = glitch_bad;
        ev[INT_REFUSE] = cmd_take && ((rx.data == CMD_SENSE && !sense_ok)
            || (rx.data == CMD_PROG && !prog_ok));
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            int_stat_reg <= '0;
        end
        else if (wr_acc && paddr == OFS_INT_STAT)
        begin
            int_stat_reg <= (int_stat_reg & ~pwdata[INT_W-1:0]) | ev;
        end
        else
        begin
            int_stat_reg <= int_stat_reg | ev;
        end
    end
    assign irq = |(int_stat_reg & int_mask_reg);

    // ==================================================
    // APB slave
    assign wr_acc = psel & penable & pwrite & ~pslverr_reg;
    assign addr_wr = wr_acc && paddr == OFS_ADDR;
    assign pready = 1'b1;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= CTRL_RESET;
            int_mask_reg <= '0;
        end
        else if (wr_acc && paddr == OFS_CTRL)
        begin
            ctrl_reg <= pwdata[CTRL_W-1:0];
        end
        else if (wr_acc && paddr == OFS_INT_MASK)
        begin
            int_mask_reg <= pwdata[INT_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= 32'h0;
            pslverr_reg <= 1'b0;
        end
        else if (psel && !penable)
        begin
            pslverr_reg <= 1'b0;
            unique case (paddr)
                OFS_CTRL: prdata_reg <= 32'(ctrl_reg);
                OFS_STATUS: prdata_reg <= 32'({common_electrode_voltage_reg, 7'h00, busy_reg});
                OFS_ADDR: prdata_reg <= 32'({y_reg, x_reg});
                OFS_COMMON_ELECTRODE_VOLTAGE: prdata_reg <= 32'(common_electrode_voltage_reg);
                OFS_DUR: prdata_reg <= 32'(dur_reg);
                OFS_GLITCH: prdata_reg <= 32'({glitch1_reg, glitch0_reg});
                OFS_INT_STAT: prdata_reg <= 32'(int_stat_reg);
                OFS_INT_MASK: prdata_reg <= 32'(int_mask_reg);
                default:
                begin
                    prdata_reg <= 32'h0;
                    pslverr_reg <= 1'b1;
                end
            endcase
        end
    end

    // ==================================================
    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_RED_HOLD: assert property (
        (cmd_reg == CMD_WR_RED && !(rx_valid && !rx.dc))
        |=> cmd_reg == CMD_WR_RED)
        else $error("red write mode dropped without a command");
    AST_ADDR_X: assert property (
        (red_we && !addr_wr && !ctrl_reg.address_step_direction
        && ctrl_reg.address_inc_dec_select[0])
        |=> x_reg == X_W'($past(x_reg) + 1'b1))
        else $error("address counter did not step in x");
    AST_RD_STEP: assert property (
        (rd_done && !first_reg && !addr_wr) |=> !$stable({y_reg, x_reg}))
        else $error("read did not advance the address");
    AST_RD_PLANE: assert property (
        (cmd_reg == CMD_RD_RAM && !first_reg)
        |=> tx_byte_reg == $past(ctrl_reg.read_red ? red_rdata : bw_rdata))
        else $error("readback from the wrong plane");
    AST_DUMMY: assert property (
        (cmd_take && rx.data == CMD_RD_RAM) |=> ##1 tx_byte_reg == DUMMY_BYTE)
        else $error("first read byte is not the dummy");
    AST_SENSE_GO: assert property (
        (cmd_take && rx.data == CMD_SENSE && sense_ok)
        |=> sense_active && busy ##1 sense_active)
        else $error("sense did not start");
    AST_SENSE_CNT: assert property (
        (op_reg != OP_IDLE && cnt_reg != '0)
        |=> op_reg == $past(op_reg) && cnt_reg == CNT_W'($past(cnt_reg) - 1'b1))
        else $error("settling count did not step");
    AST_CAPTURE: assert property (
        (op_reg == OP_SENSE && cnt_reg == '0)
        |=> common_electrode_voltage_reg == $past(sensed_common_electrode_voltage) && !busy)
        else $error("sensed voltage not stored");
    AST_BUSY: assert property (
        $fell(busy) |-> $past(cnt_reg) == '0 && op_reg == OP_IDLE)
        else $error("busy released early");
    AST_STATUS: assert property (
        (cmd_reg == CMD_STATUS) |=> tx_byte_reg[STAT_BUSY_BIT] == $past(busy))
        else $error("status busy bit wrong");
    AST_DUR: assert property (
        (data_take && cmd_reg == CMD_SENSE_DUR && pidx_reg == 2'd0)
        |=> dur_reg == $past(rx.data[DUR_W-1:0]))
        else $error("duration byte not taken");
    AST_PROG: assert property (
        (cmd_take && rx.data == CMD_PROG && prog_ok)
        |=> otp_write_en && otp_wdata == common_electrode_voltage_reg)
        else $error("programming did not start");
    AST_DC: assert property (
        data_take |=> cmd_reg == $past(cmd_reg))
        else $error("data byte changed the command");
endmodule

//--- verif/pvc_host_model.sv
// Purpose: Host side of the serial command link
// Assumes: Mode 0, 320 ns bit period
// Notes: Select stays low after start-up
module pvc_host_model
(
    // Clock
    input logic pclk,
    // Link pins
    output logic sclk,
    output logic csn,
    output logic dcn,
    output logic sda_in,
    input logic sda_out,
    input logic sda_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        sclk = 1'b0;
        csn = 1'b1;
        dcn = 1'b1;
        sda_in = 1'b0;
        repeat (6) @(posedge pclk);
        csn <= 1'b0;
    end
    // Read bits are taken at rising edges
    task automatic xfer(input logic dc, input logic [7:0] d,
                        output logic [7:0] r);
        for (int i = 7; i >= 0; i--)
        begin
            @(posedge pclk);
            sclk <= 1'b0;
            dcn <= dc;
            sda_in <= d[i];
            repeat (4) @(posedge pclk);
            sclk <= 1'b1;
            // Undriven line reads inverted, so a missing enable shows
            r[i] = sda_oe_n ? ~sda_out : sda_out;
            repeat (3) @(posedge pclk);
        end
        @(posedge pclk);
        sclk <= 1'b0;
        sda_in <= ~d[0];
    endtask
endmodule

//--- verif/panel_ram_and_common_electrode_voltage_commands_tb.sv
// Purpose: Self-checking bench of the command handler
// Assumes: Short sense and programming counts
// Notes: Serial traffic through the host model
module panel_ram_and_common_electrode_voltage_commands_tb
    import pvc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SU = 3;
    localparam int PT = 4;
    logic pclk, pready, pslverr, err, sclk, csn, dcn, sda_in, sda_out;
    logic sda_oe_n, sense_active, otp_write_en, busy, irq;
    logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic bw_wr_en = 1'b0;
    logic [7:0] paddr = 8'h00, bw_wr_data = 8'h00, sensed_common_electrode_voltage = 8'h5a;
    logic [7:0] otp_wdata, otp_seen, b;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int errors, checks, busy_cnt, cnt0, act_cnt, act0;
    pvc_top #(.SENSE_UNIT(SU), .PROG_TIME(PT)) pvc_top_inst (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sclk(sclk), .csn(csn), .dcn(dcn), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .bw_wr_en(bw_wr_en),
        .bw_wr_data(bw_wr_data), .sensed_common_electrode_voltage(sensed_common_electrode_voltage),
        .sense_active(sense_active), .otp_write_en(otp_write_en),
        .otp_wdata(otp_wdata), .busy(busy), .irq(irq));
    pvc_host_model pvc_host_model_inst (.pclk(pclk), .sclk(sclk),
        .csn(csn), .dcn(dcn), .sda_in(sda_in), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n));
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        busy_cnt <= busy_cnt + int'(busy);
        act_cnt <= act_cnt + int'(sense_active);
        if (otp_write_en)
            otp_seen <= otp_wdata;
    end
    // ==========================================
    // Tasks
    task automatic chk(input string n, input logic [31:0] s, e);
        checks++;
        if (s !== e)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cmd(input logic [7:0] c);
        pvc_host_model_inst.xfer(1'b0, c, b);
    endtask
    task automatic dat(input logic [7:0] d);
        pvc_host_model_inst.xfer(1'b1, d, b);
    endtask
    task automatic rx(input string n, input logic [7:0] e);
        pvc_host_model_inst.xfer(1'b1, 8'h00, b);
        chk(n, {24'h0, b}, {24'h0, e});
    endtask
    task automatic idle();
        repeat (4) @(posedge pclk);
        while (busy !== 1'b0)
        begin
            @(posedge pclk);
        end
        repeat (2) @(posedge pclk);
    endtask
    task automatic wrap_up();
        if (errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #800000;
        errors++;
        wrap_up();
    end
    // ==========================================
    // Tests
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (10) @(posedge pclk);
        apb(1'b0, OFS_CTRL, 0);
        chk("ctrl", rd, 32'h18);
        apb(1'b0, 8'h20, 0);
        chk("slverr", {31'h0, err}, 32'h1);
        cnt0 = busy_cnt;
        cmd(CMD_SENSE);
        idle();
        chk("refused", busy_cnt - cnt0, 0);
        apb(1'b0, OFS_INT_STAT, 0);
        chk("int refuse", rd, 32'h8);
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, OFS_INT_STAT, 32'hf);
        apb(1'b1, OFS_CTRL, 32'h1f);
        apb(1'b1, OFS_INT_MASK, 32'h1);
        apb(1'b1, OFS_ADDR, 0);
        @(posedge pclk);
        bw_wr_en <= 1'b1;
        bw_wr_data <= 8'h11;
        @(posedge pclk);
        bw_wr_en <= 1'b0;
        apb(1'b1, OFS_ADDR, 0);
        cmd(CMD_WR_RED);
        dat(8'ha5);
        dat(8'h3c);
        apb(1'b0, OFS_ADDR, 0);
        chk("addr", rd, 32'h2);
        apb(1'b1, OFS_ADDR, 0);
        cmd(CMD_RD_RAM);
        rx("dummy", DUMMY_BYTE);
        rx("red0", 8'ha5);
        rx("red1", 8'h3c);
        apb(1'b1, OFS_ADDR, 0);
        apb(1'b1, OFS_CTRL, 32'h1b);
        cmd(CMD_RD_RAM);
        rx("dummy bw", DUMMY_BYTE);
        rx("bw0", 8'h11);
        cmd(CMD_SENSE_DUR);
        dat(8'h01);
        apb(1'b0, OFS_DUR, 0);
        chk("dur", rd, 32'h1);
        cnt0 = busy_cnt;
        act0 = act_cnt;
        cmd(CMD_SENSE);
        idle();
        chk("sense", busy_cnt - cnt0, 2 * SU);
        chk("sense act", act_cnt - act0, 2 * SU);
        apb(1'b0, OFS_COMMON_ELECTRODE_VOLTAGE, 0);
        chk("common_electrode_voltage", rd, 32'h5a);
        chk("irq", {31'h0, irq}, 32'h1);
        apb(1'b1, OFS_INT_STAT, 32'h1);
        @(posedge pclk);
        chk("irq clr", {31'h0, irq}, 32'h0);
        cnt0 = busy_cnt;
        cmd(CMD_PROG);
        idle();
        chk("prog", busy_cnt - cnt0, PT);
        chk("otp", {24'h0, otp_seen}, 32'h5a);
        cmd(CMD_GLITCH);
        dat(GLITCH_B0);
        dat(GLITCH_B1);
        apb(1'b0, OFS_GLITCH, 0);
        chk("glitch", rd, 32'h6304);
        chk("oe idle", {31'h0, sda_oe_n}, 32'h1);
        apb(1'b0, OFS_INT_STAT, 0);
        chk("int", rd, 32'h2);
        cmd(CMD_STATUS);
        rx("status", 8'h02);
        wrap_up();
    end
endmodule
